// file: verilog/tcs_i2c_slave.sv
// tcs_i2c_slave: two-wire slave port giving a host access to the register set
// assumes: master supplies scl; sda is open drain, resolved outside
`timescale 1ns/100ps
module tcs_i2c_slave
#(
  parameter logic [6:0] SLAVE_ADDR = tcs_pkg::DEFAULT_SLAVE_ADDR  // factory address
)
(
  input  wire logic                 clock_i,        // 100 MHz clock
  input  wire logic                 rst_n_i,        // async reset, active low
  input  wire logic                 scl_i,          // bus clock pin
  input  wire logic                 sda_i,          // bus data pin in
  output logic                      sda_o,          // bus data pin out, always 0
  output logic                      sda_oe_o,       // high while pulling sda low
  input  wire logic                 nvm_addr_vld_i, // nvm holds an address
  input  wire logic [6:0]           nvm_addr_i,     // address from nvm location
  input  wire logic                 phase_i,        // start of processing phase
  input  wire logic [7:0]           status_i [0:7], // live status bytes 0x00..0x07
  input  wire logic [7:0]           shadow_stat_i,  // shadow memory status 0x08
  output tcs_pkg::tcs_reg_wr_type   wr_o,           // applied write at phase start
  output logic [7:0]                ctrl_o [0:15]   // applied shadow values 0x00..0x0f
);
  typedef enum logic [2:0] {
    TCS_IDLE, TCS_ADDR, TCS_ADDR_ACK, TCS_RX, TCS_RX_ACK, TCS_TX, TCS_TX_ACK
  } tcs_state_type;

  tcs_pkg::tcs_line_evt_type evt;
  tcs_state_type state;
  logic [7:0]    shift;
  logic [2:0]    bit_cnt;
  logic [7:0]    ptr;
  logic          have_idx;
  logic          rd_dir;
  logic [6:0]    my_addr;
  logic [7:0]    shadow [0:255];
  logic [7:0]    pend_data;
  logic [7:0]    pend_idx;
  logic          pend;
  logic [7:0]    rd_byte;
  tcs_pkg::tcs_group_type grp;

  tcs_bit_sampler tcs_bit_sampler_inst
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .evt_o   (evt)
  );

  // address picked after reset release, not in the reset branch
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      my_addr <= tcs_pkg::DEFAULT_SLAVE_ADDR;
    else
      my_addr <= nvm_addr_vld_i ? nvm_addr_i : SLAVE_ADDR;
  end

  // register grouping; 0x01 and 0x03..0x06 reserved
  always_comb
  begin
    case (ptr)
      tcs_pkg::IDX_IRQ_SRC, tcs_pkg::IDX_BTN_STAT,
      tcs_pkg::IDX_GPI_STAT, tcs_pkg::IDX_SHADOW_STAT: grp = tcs_pkg::TCS_GRP_STATUS;
      tcs_pkg::IDX_KEY_HI, tcs_pkg::IDX_KEY_LO:        grp = tcs_pkg::TCS_GRP_GATEWAY;
      tcs_pkg::IDX_SOFT_RESET:                         grp = tcs_pkg::TCS_GRP_CONTROL;
      default:
        grp = (ptr >= tcs_pkg::IDX_CTRL_FIRST && ptr <= tcs_pkg::IDX_CTRL_LAST) ?
              tcs_pkg::TCS_GRP_CONTROL : tcs_pkg::TCS_GRP_NONE;
    endcase
  end

  always_comb
  begin
    case (grp)
      tcs_pkg::TCS_GRP_STATUS:
        rd_byte = (ptr == tcs_pkg::IDX_SHADOW_STAT) ? shadow_stat_i : status_i[ptr[2:0]];
      tcs_pkg::TCS_GRP_CONTROL,
      tcs_pkg::TCS_GRP_GATEWAY: rd_byte = shadow[ptr];
      default:                  rd_byte = 8'h00;
    endcase
  end

  // bus protocol engine
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state    <= TCS_IDLE;
      shift    <= 8'h00;
      bit_cnt  <= 3'h0;
      ptr      <= 8'h00;
      have_idx <= 1'b0;
      rd_dir   <= 1'b0;
      sda_oe_o <= 1'b0;
      pend     <= 1'b0;
      pend_idx <= 8'h00;
      pend_data <= 8'h00;
    end
    else
    begin
      if (phase_i)
        pend <= 1'b0;
      if (evt.stop)
      begin
        state    <= TCS_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (evt.start)
      begin
        state    <= TCS_ADDR;
        bit_cnt  <= 3'h0;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (state)
          TCS_ADDR, TCS_RX:
            if (evt.scl_rise)
            begin
              shift   <= {shift[6:0], evt.sda};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == tcs_pkg::BIT_LAST)
                state <= (state == TCS_ADDR) ? TCS_ADDR_ACK : TCS_RX_ACK;
            end
          TCS_ADDR_ACK:
            if (evt.scl_fall && !sda_oe_o)
            begin
              if (shift[7:1] == my_addr)
              begin
                sda_oe_o <= 1'b1;
                rd_dir   <= shift[0];
                if (shift[0] == tcs_pkg::DIR_WRITE)
                  have_idx <= 1'b0;
              end
              else
                state <= TCS_IDLE;
            end
            else if (evt.scl_fall)
            begin
              if (rd_dir == tcs_pkg::DIR_READ)
              begin
                state    <= TCS_TX;
                shift    <= rd_byte;
                sda_oe_o <= !rd_byte[7];
                bit_cnt  <= 3'h1;
              end
              else
              begin
                state    <= TCS_RX;
                sda_oe_o <= 1'b0;
              end
            end
          TCS_RX_ACK:
            if (evt.scl_fall && !sda_oe_o)
            begin
              sda_oe_o <= 1'b1;
              if (!have_idx)
              begin
                ptr      <= shift;
                have_idx <= 1'b1;
              end
              else
              begin
                if (grp == tcs_pkg::TCS_GRP_CONTROL || grp == tcs_pkg::TCS_GRP_GATEWAY)
                begin
                  pend      <= 1'b1;
                  pend_idx  <= ptr;
                  pend_data <= shift;
                end
                ptr <= ptr + 8'h01;
              end
            end
            else if (evt.scl_fall)
            begin
              state    <= TCS_RX;
              sda_oe_o <= 1'b0;
            end
          TCS_TX:
            if (evt.scl_fall)
            begin
              if (bit_cnt == 3'h0)
              begin
                state    <= TCS_TX_ACK;
                sda_oe_o <= 1'b0;
                ptr      <= ptr + 8'h01;
              end
              else
              begin
                sda_oe_o <= !shift[~bit_cnt];
                bit_cnt  <= bit_cnt + 3'h1;
              end
            end
          TCS_TX_ACK:
            if (evt.scl_rise)
            begin
              if (evt.sda)
                state <= TCS_IDLE;
            end
            else if (evt.scl_fall)
            begin
              state    <= TCS_TX;
              shift    <= rd_byte;
              sda_oe_o <= !rd_byte[7];
              bit_cnt  <= 3'h1;
            end
          default: state <= TCS_IDLE;
        endcase
      end
    end
  end

  // shadow memory: volatile, cleared at power-up reset
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < tcs_pkg::REG_COUNT; i++)
        shadow[i] <= 8'h00;
      wr_o <= '0;
    end
    else
    begin
      wr_o.wr <= 1'b0;
      if (phase_i && pend)
      begin
        shadow[pend_idx] <= pend_data;
        wr_o.wr   <= 1'b1;
        wr_o.idx  <= pend_idx;
        wr_o.data <= pend_data;
      end
    end
  end

  generate
    for (genvar g = 0; g < tcs_pkg::CTRL_OUT_COUNT; g++)
    begin : g_ctrl
      always_comb ctrl_o[g] = shadow[g];
    end
  endgenerate

  assign sda_o = 1'b0;

  sequence s_addr_ack;
    state == TCS_ADDR_ACK && evt.scl_fall && !sda_oe_o && shift[7:1] == my_addr;
  endsequence

  AST_ADDR_ACK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_addr_ack |=> sda_oe_o)
    else $error("matching address not acknowledged");
  AST_NO_FOREIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == TCS_ADDR_ACK && evt.scl_fall && !sda_oe_o && shift[7:1] != my_addr)
      |=> state == TCS_IDLE && !sda_oe_o)
    else $error("foreign address acknowledged");
  AST_WR_DELAY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (wr_o.wr) |-> $past(phase_i))
    else $error("write applied outside phase start");
  AST_PTR_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == TCS_RX_ACK && evt.scl_fall && !sda_oe_o && have_idx)
      |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance");
  AST_IDX_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == TCS_RX_ACK && evt.scl_fall && !sda_oe_o && !have_idx)
      |=> ptr == $past(shift))
    else $error("pointer not loaded from index");
  AST_DATA_ACK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == TCS_RX_ACK && evt.scl_fall && !sda_oe_o) |=> sda_oe_o)
    else $error("data byte not acknowledged");
  AST_NACK_END: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == TCS_TX_ACK && evt.scl_rise && evt.sda && !evt.stop && !evt.start)
      |=> state == TCS_IDLE)
    else $error("nack did not end read");
  AST_UNMAPPED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (grp == tcs_pkg::TCS_GRP_NONE) |-> rd_byte == 8'h00)
    else $error("unmapped read not zero");
  AST_DROP_WR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == TCS_RX_ACK && evt.scl_fall && !sda_oe_o && have_idx &&
     grp == tcs_pkg::TCS_GRP_NONE) |=> pend_data == $past(pend_data))
    else $error("unmapped write not dropped");
  AST_STOP_REL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    evt.stop |=> !sda_oe_o ##1 state == TCS_IDLE)
    else $error("stop did not release bus");
endmodule

// file: verilog/tcs_pkg.sv
// tcs_pkg: shared constants and types for the touch controller serial slave port
// assumes: used by tcs_i2c_slave and tcs_bit_sampler, one 100 MHz clock domain
package tcs_pkg;
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2b;
  localparam logic [7:0] NVM_ADDR_LOC       = 8'h04;
  localparam int         CLK_HZ             = 100_000_000;
  localparam int         STD_RATE_BPS       = 100_000;
  localparam int         FAST_RATE_BPS      = 400_000;
  // shortest scl high time supported at fast mode, in ns
  localparam int         SCL_HIGH_MIN_NS    = 600;
  localparam int         SCL_HIGH_MIN_CYC   = (SCL_HIGH_MIN_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int         REG_COUNT          = 256;
  localparam logic       DIR_WRITE          = 1'b0;
  localparam logic       DIR_READ           = 1'b1;
  localparam logic [2:0] BIT_LAST           = 3'h7;
  // register indices seen on the bus
  localparam logic [7:0] IDX_IRQ_SRC        = 8'h00;
  localparam logic [7:0] IDX_BTN_STAT       = 8'h02;
  localparam logic [7:0] IDX_GPI_STAT       = 8'h07;
  localparam logic [7:0] IDX_SHADOW_STAT    = 8'h08;
  localparam logic [7:0] IDX_CTRL_FIRST     = 8'h09;
  localparam logic [7:0] IDX_CTRL_LAST      = 8'h0e;
  localparam logic [7:0] IDX_KEY_HI         = 8'hac;
  localparam logic [7:0] IDX_KEY_LO         = 8'had;
  localparam logic [7:0] IDX_SOFT_RESET     = 8'hb1;
  localparam int         CTRL_OUT_COUNT     = 16;

  typedef enum logic [1:0] {
    TCS_GRP_NONE,
    TCS_GRP_STATUS,
    TCS_GRP_CONTROL,
    TCS_GRP_GATEWAY
  } tcs_group_type;

  // line events found on the sampled bus
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } tcs_line_evt_type;

  // register side write port
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } tcs_reg_wr_type;
endpackage

// file: verilog/tcs_bit_sampler.sv
// tcs_bit_sampler: synchronises scl/sda and detects edges, start and stop
// assumes: raw pins from the bus, asynchronous to clock_i
`timescale 1ns/100ps
module tcs_bit_sampler
(
  input  wire logic                      clock_i,  // system clock
  input  wire logic                      rst_n_i,  // async reset, active low
  input  wire logic                      scl_i,    // raw bus clock
  input  wire logic                      sda_i,    // raw bus data
  output tcs_pkg::tcs_line_evt_type      evt_o     // sampled events
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  always_comb
  begin
    evt_o.scl_rise = scl_sync[1] && !scl_prev;
    evt_o.scl_fall = !scl_sync[1] && scl_prev;
    evt_o.start    = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
    evt_o.stop     = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
    evt_o.sda      = sda_sync[1];
  end
endmodule

// file: tb/tcs_i2c_master.sv
// tcs_i2c_master: behavioural bus master driving the slave port
// assumes: sda has a pull-up resolved in the bench; scl stands high when idle
`timescale 1ns/100ps
module tcs_i2c_master
(
  output logic      scl_o,      // bus clock
  output logic      sda_pull_o, // high while pulling sda low
  input  wire logic sda_i       // resolved sda level
);
  localparam time HALF = 80ns;
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // also serves as repeated start
  task automatic start_cond();
    sda_pull_o = 1'b0;
    #(HALF-20) scl_o = 1'b1;
    #(HALF/2) sda_pull_o = 1'b1;
    #(HALF/2) scl_o = 1'b0;
    #20;
  endtask
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #(HALF-20) scl_o = 1'b1;
    #(HALF/2) sda_pull_o = 1'b0;
    #HALF;
  endtask
  // data held 20 ns past the scl fall
  task automatic put_bit(input logic b, output logic r);
    sda_pull_o = ~b;
    #(HALF-20) scl_o = 1'b1;
    #(HALF/2) r = sda_i;
    #(HALF/2) scl_o = 1'b0;
    #20;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(~more, r);
  endtask
endmodule

// file: tb/tcs_i2c_slave_tb_top.sv
// tcs_i2c_slave_tb_top: self-checking bench for the slave port
// assumes: tcs_i2c_master as bus master, pull-up on sda
`timescale 1ns/100ps
module tcs_i2c_slave_tb_top;
  logic                    clock_i = 1'b0;
  logic                    rst_n_i = 1'b0;
  logic                    scl, pull, ack, sda_o, sda_oe_o;
  logic                    phase_i = 1'b0;
  logic                    nvm_addr_vld_i = 1'b0;
  logic [6:0]              nvm_addr_i = 7'h31;
  logic [6:0]              sa = tcs_pkg::DEFAULT_SLAVE_ADDR;
  logic [7:0]              status_i [0:7];
  logic [7:0]              shadow_stat_i = 8'h5a;
  logic [7:0]              ctrl_o [0:15];
  logic [7:0]              exp_reg [0:255];
  logic [7:0]              v;
  tcs_pkg::tcs_reg_wr_type wr_o, last_wr;
  int                      error_cnt, n_tests, cyc, wr_cnt, n0;
  wire                     sda = ~pull & (~sda_oe_o | sda_o);

  always #5 clock_i = ~clock_i;
  tcs_i2c_slave tcs_i2c_slave_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .nvm_addr_vld_i(nvm_addr_vld_i),
    .nvm_addr_i(nvm_addr_i), .phase_i(phase_i), .status_i(status_i),
    .shadow_stat_i(shadow_stat_i), .wr_o(wr_o), .ctrl_o(ctrl_o));
  tcs_i2c_master tcs_i2c_master_inst (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));

  always @(posedge clock_i)
  begin
    cyc++;
    if (wr_o.wr === 1'b1)
    begin
      last_wr <= wr_o;
      wr_cnt <= wr_cnt + 1;
    end
    if (cyc == 60000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic writable(input logic [7:0] i);
    return (i >= 8'h09 && i <= 8'h0e) || i == 8'hac || i == 8'had || i == 8'hb1;
  endfunction
  task automatic pulse_phase();
    @(negedge clock_i) phase_i = 1'b1;
    @(negedge clock_i) phase_i = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic addr_idx(input logic [7:0] idx);
    tcs_i2c_master_inst.start_cond();
    tcs_i2c_master_inst.wr_byte({sa, 1'b0}, ack);
    check({7'h00, ack}, 8'h01);
    tcs_i2c_master_inst.wr_byte(idx, ack);
    check({7'h00, ack}, 8'h01);
  endtask
  task automatic wr_frame(input logic [7:0] idx, input logic [7:0] d[$], input logic ph);
    addr_idx(idx);
    foreach (d[k])
    begin
      tcs_i2c_master_inst.wr_byte(d[k], ack);
      check({7'h00, ack}, 8'h01);
      if (ph)
        pulse_phase();
      if (writable(8'(idx + k)))
        exp_reg[idx+k] = d[k];
    end
    tcs_i2c_master_inst.stop_cond();
  endtask
  task automatic rd_frame(input logic [7:0] idx, input int n);
    addr_idx(idx);
    tcs_i2c_master_inst.start_cond();
    tcs_i2c_master_inst.wr_byte({sa, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    for (int k = 0; k < n; k++)
    begin
      tcs_i2c_master_inst.rd_byte(k < n - 1, v);
      check(v, exp_reg[idx+k]);
    end
    tcs_i2c_master_inst.stop_cond();
  endtask
  task automatic probe(input logic [6:0] a, input logic exp_ack);
    tcs_i2c_master_inst.start_cond();
    tcs_i2c_master_inst.wr_byte({a, 1'b0}, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
    tcs_i2c_master_inst.stop_cond();
  endtask

  task automatic t_write_single();
    n0 = wr_cnt;
    wr_frame(8'h0a, '{8'h55}, 1'b0);
    check(ctrl_o[10], 8'h00);
    pulse_phase();
    check(8'(wr_cnt - n0), 8'h01);
    check(last_wr.idx, 8'h0a);
    check(last_wr.data, 8'h55);
    check(ctrl_o[10], 8'h55);
  endtask
  task automatic t_burst();
    wr_frame(8'h09, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66}, 1'b1);
    for (int k = 9; k < 15; k++)
      check(ctrl_o[k], exp_reg[k]);
    rd_frame(8'h09, 6);
    wr_frame(8'hac, '{8'h3c, 8'hc3}, 1'b1);
    rd_frame(8'hac, 2);
    wr_frame(8'hb1, '{8'h9d}, 1'b1);
    rd_frame(8'hb1, 1);
  endtask
  task automatic t_status();
    wr_frame(8'h02, '{8'hff}, 1'b1);
    wr_frame(8'h0f, '{8'hff}, 1'b1);
    rd_frame(8'h00, 16);
  endtask
  task automatic t_address();
    probe(7'h2c, 1'b0);
    @(negedge clock_i) nvm_addr_vld_i = 1'b1;
    sa = 7'h31;
    wr_frame(8'h0b, '{8'h77}, 1'b1);
    check(ctrl_o[11], 8'h77);
    probe(tcs_pkg::DEFAULT_SLAVE_ADDR, 1'b0);
    @(negedge clock_i) nvm_addr_vld_i = 1'b0;
    sa = tcs_pkg::DEFAULT_SLAVE_ADDR;
    probe(sa, 1'b1);
  endtask
  task automatic t_reset();
    @(negedge clock_i) rst_n_i = 1'b0;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    check(ctrl_o[9], 8'h00);
    for (int k = 0; k < 256; k++)
      if (writable(8'(k)))
        exp_reg[k] = 8'h00;
    repeat (5) @(negedge clock_i);
    rd_frame(8'h09, 6);
  endtask

  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    for (int k = 0; k < 256; k++)
      exp_reg[k] = 8'h00;
    for (int k = 0; k < 8; k++)
      status_i[k] = 8'h40 + 8'(k);
    exp_reg[0] = 8'h40;
    exp_reg[2] = 8'h42;
    exp_reg[7] = 8'h47;
    exp_reg[8] = 8'h5a;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (5) @(negedge clock_i);
    t_write_single();
    t_burst();
    t_status();
    t_address();
    t_reset();
    summarize();
  end
endmodule
